// ---- core_fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    input wire logic [3:0] ack_delay,
    output logic vec_ack,
    output logic [15:0] vec_data
);
    logic [3:0] cnt;
    // ----------------------------------------
    // vector fetch: handler = {addr[7:0], ~addr[7:0]}
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_ack <= 1'b0;
            vec_data <= 16'h0000;
            cnt <= 4'h0;
        end
        else if (vec_req && !vec_ack && cnt >= ack_delay)
        begin
            vec_ack <= 1'b1;
            vec_data <= {vec_addr[7:0], ~vec_addr[7:0]};
            cnt <= 4'h0;
        end
        else
        begin
            vec_ack <= 1'b0;
            // toggles so a stale handler never looks valid
            vec_data <= ~vec_data;
            cnt <= (vec_req && !vec_ack) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule // core_fetch_model
`default_nettype wire

// ---- exc_pkg.sv ----
// Contract
// RULE1 - reset outranks every other source and entry starts once the reset pin is released.
// RULE2 - a watchdog overflow resets the chip and runs the same entry as the reset pin.
// RULE3 - the trap instruction enters through one of four vectors picked by its two-bit field.
// RULE4 - a trap is taken in program execution whatever the interrupt mask bit holds.
// RULE5 - maskable requests stay blocked while the mask bit is 1; non-maskable and break do not.
// RULE6 - a pending request is entered only at the end of an instruction, never mid-way.
// RULE7 - of several pending requests the one of highest fixed priority is served first.
// RULE8 - vectors: reset 0 at 0x0000, non-maskable 7 at 0x000e, traps 8-11 from 0x0010, break 12.
// RULE9 - vectors 1 to 6, locations 0x0002 to 0x000d, are reserved and never used.
// RULE10 - the non-maskable edge select picks the falling edge at 0 and the rising edge at 1.
// RULE11 - each of the four request pins has an edge select: 0 falling edge, 1 rising edge.
// RULE12 - all five edge selects are read/write and reset to 0.
// RULE13 - the reserved edge select bits always read 1 and ignore writes.
// RULE14 - on entry the 16-bit handler address is fetched from the vector and loaded into the pc.
// RULE15 - accepting a maskable request sets the interrupt mask bit.
package exc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_EDGE_SEL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_STATE = 12'h00c;
    localparam int NMI_SEL_BIT = 7;
    localparam logic [7:0] EDGE_RSVD = 8'h70;
    localparam logic [7:0] EDGE_RW = 8'h8f;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    // ----------------------------------------
    // event status bits
    // ----------------------------------------
    localparam int ST_W = 5;
    localparam int ST_RESET = 0;
    localparam int ST_NMI = 1;
    localparam int ST_TRAP = 2;
    localparam int ST_BREAK = 3;
    localparam int ST_REQ = 4;
    // ----------------------------------------
    // vectors
    // ----------------------------------------
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_RSVD_LO = 5'h01;
    localparam logic [4:0] VEC_RSVD_HI = 5'h06;
    localparam logic [4:0] VEC_NMI = 5'h07;
    localparam logic [4:0] VEC_TRAP0 = 5'h08;
    localparam logic [4:0] VEC_BREAK = 5'h0c;
    localparam logic [4:0] VEC_REQ0 = 5'h0e;
    typedef enum logic [1:0] {st_hold, st_run, st_fetch} exc_state_e;
endpackage

// ---- exc_vector_ctrl.sv ----
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module exc_vector_ctrl
    import exc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic wdt_overflow,
    input wire logic nmi_pin,
    input wire logic [3:0] ext_request_pins,
    input wire logic instr_done,
    input wire logic software_trap_instr,
    input wire logic [1:0] trap_num,
    input wire logic ccr_ibit,
    input wire logic break_req,
    input wire logic vec_ack,
    input wire logic [15:0] vec_data,
    output logic core_reset,
    output logic vec_req,
    output logic [15:0] vec_addr,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic set_ibit,
    output logic [4:0] vector_num,
    output logic irq
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction
    function automatic logic [15:0] vec_to_addr(input logic [4:0] v);
        vec_to_addr = {10'h000, v, 1'b0};
    endfunction

    // ----------------------------------------
    // pin detection
    // ----------------------------------------
    logic [7:0] edge_sel_r, edge_sel_nxt;
    logic [4:0] pin_in, pin_sel, pin_edge;
    logic rst_level, sys_rst;

    assign pin_in = {nmi_pin, ext_request_pins};
    assign pin_sel = {edge_sel_r[NMI_SEL_BIT], edge_sel_r[3:0]};

    for (genvar gi = 0; gi < 5; gi++)
    begin : g_pin
        pin_edge_detect u_det
        (
            .pclk(pclk),
            .presetn(presetn),
            .pin(pin_in[gi]),
            .rise_sel(pin_sel[gi]),
            .level(),
            .edge_seen(pin_edge[gi])
        );
    end

    // rise_sel unused: only the level of the reset pin matters
    pin_edge_detect u_rst
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin(reset_pin_n),
        .rise_sel(1'b0),
        .level(rst_level),
        .edge_seen()
    );

    assign sys_rst = ~rst_level | wdt_overflow; // RULE1 RULE2

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, st_set, st_clr;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt, setup, access, mapped, nmi_pend_r;
    exc_state_e state_r;
    logic [3:0] req_pend_r;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign mapped = hit(paddr, ADDR_EDGE_SEL) | hit(paddr, ADDR_STATUS)
        | hit(paddr, ADDR_MASK) | hit(paddr, ADDR_STATE);

    always_comb
    begin
        prdata_nxt = prdata;
        pready_nxt = setup;
        pslverr_nxt = setup & ~mapped;
        edge_sel_nxt = edge_sel_r;
        mask_nxt = mask_r;
        st_clr = '0;
        // data is captured in setup so access has it straight from a flop
        if (setup)
        begin
            prdata_nxt = 32'h0000_0000;
            if (hit(paddr, ADDR_EDGE_SEL))
                prdata_nxt[7:0] = edge_sel_r | EDGE_RSVD; // RULE13
            else if (hit(paddr, ADDR_STATUS))
                prdata_nxt[ST_W-1:0] = status_r;
            else if (hit(paddr, ADDR_MASK))
                prdata_nxt[ST_W-1:0] = mask_r;
            else if (hit(paddr, ADDR_STATE))
                prdata_nxt[15:0] = {req_pend_r, nmi_pend_r, ccr_ibit,
                    state_r, 3'h0, vector_num};
        end
        if (access & pwrite & hit(paddr, ADDR_EDGE_SEL))
            edge_sel_nxt = pwdata[7:0] & EDGE_RW; // RULE12 RULE13
        if (access & pwrite & hit(paddr, ADDR_MASK))
            mask_nxt = pwdata[ST_W-1:0];
        // only bits actually reported are cleared; a fresh event survives
        if (access & ~pwrite & hit(paddr, ADDR_STATUS))
            st_clr = prdata[ST_W-1:0];
        if (sys_rst)
            edge_sel_nxt = EDGE_RESET; // RULE12
        status_nxt = (status_r & ~st_clr) | st_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            edge_sel_r <= EDGE_RESET;
            mask_r <= '0;
            status_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            edge_sel_r <= edge_sel_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            irq <= |(status_nxt & mask_nxt);
        end
    end

    // ----------------------------------------
    // exception sequencer
    // ----------------------------------------
    exc_state_e state_nxt;
    logic [3:0] req_pend_nxt, req_open, req_take;
    logic nmi_pend_nxt, trap_pend_r, trap_pend_nxt, core_reset_nxt;
    logic vec_req_nxt, pc_load_nxt, set_ibit_nxt, take_mask;
    logic [1:0] trap_id_r, trap_id_nxt;
    logic [15:0] vec_addr_nxt, pc_value_nxt;
    logic [4:0] vector_num_nxt, sel_vec;
    // maskable requests are gated by the mask bit only
    assign req_open = ccr_ibit ? 4'h0 : req_pend_r; // RULE5

    always_comb
    begin
        state_nxt = state_r;
        req_take = 4'h0;
        take_mask = 1'b0;
        st_set = '0;
        sel_vec = VEC_RESET;
        nmi_pend_nxt = nmi_pend_r;
        trap_pend_nxt = trap_pend_r;
        trap_id_nxt = trap_id_r;
        core_reset_nxt = 1'b0;
        vec_req_nxt = vec_req;
        vec_addr_nxt = vec_addr;
        pc_load_nxt = 1'b0;
        pc_value_nxt = pc_value;
        set_ibit_nxt = 1'b0;
        vector_num_nxt = vector_num;
        case (state_r)
            st_hold:
            begin
                core_reset_nxt = 1'b1;
                // entry begins on the release of the reset condition
                if (!sys_rst)
                begin
                    state_nxt = st_fetch; // RULE1
                    vec_req_nxt = 1'b1;
                    vector_num_nxt = VEC_RESET; // RULE8
                    vec_addr_nxt = vec_to_addr(VEC_RESET); // RULE14
                    st_set[ST_RESET] = 1'b1;
                    core_reset_nxt = 1'b0;
                end
            end
            st_run:
            begin
                // latched first: a trap beaten by nmi must not be lost
                if (software_trap_instr) // RULE4
                begin
                    trap_pend_nxt = 1'b1;
                    trap_id_nxt = trap_num;
                end
                // only at an instruction boundary
                if (instr_done) // RULE6
                begin
                    state_nxt = st_fetch;
                    if (nmi_pend_r) // RULE7
                    begin
                        sel_vec = VEC_NMI;
                        nmi_pend_nxt = 1'b0;
                        st_set[ST_NMI] = 1'b1;
                    end
                    else if (trap_pend_r | software_trap_instr) // RULE4
                    begin
                        sel_vec = VEC_TRAP0 + {3'h0, software_trap_instr
                            ? trap_num : trap_id_r}; // RULE3
                        trap_pend_nxt = 1'b0;
                        st_set[ST_TRAP] = 1'b1;
                    end
                    else if (break_req)
                    begin
                        sel_vec = VEC_BREAK;
                        st_set[ST_BREAK] = 1'b1;
                    end
                    else if (|req_open)
                    begin
                        take_mask = 1'b1;
                        st_set[ST_REQ] = 1'b1;
                        for (int i = 3; i >= 0; i--)
                        begin
                            if (req_open[i])
                            begin
                                req_take = 4'h1 << i;
                                sel_vec = VEC_REQ0 + 5'(i);
                            end
                        end
                    end
                    else
                        state_nxt = st_run;
                    if (state_nxt == st_fetch)
                    begin
                        vec_req_nxt = 1'b1;
                        vector_num_nxt = sel_vec; // RULE8 RULE9
                        vec_addr_nxt = vec_to_addr(sel_vec);
                        set_ibit_nxt = take_mask; // RULE15
                    end
                end
            end
            st_fetch:
            begin
                if (vec_ack)
                begin
                    vec_req_nxt = 1'b0;
                    pc_value_nxt = vec_data; // RULE14
                    pc_load_nxt = 1'b1;
                    state_nxt = st_run;
                end
            end
            default:
                state_nxt = st_hold;
        endcase
        // new edges win over a same-cycle acceptance
        req_pend_nxt = (req_pend_r & ~req_take) | pin_edge[3:0]; // RULE11
        nmi_pend_nxt = nmi_pend_nxt | pin_edge[4]; // RULE10
        if (sys_rst) // RULE1 RULE2
        begin
            state_nxt = st_hold;
            core_reset_nxt = 1'b1;
            vec_req_nxt = 1'b0;
            pc_load_nxt = 1'b0;
            set_ibit_nxt = 1'b0;
            req_pend_nxt = 4'h0;
            nmi_pend_nxt = 1'b0;
            trap_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= st_hold;
            req_pend_r <= 4'h0;
            nmi_pend_r <= 1'b0;
            trap_pend_r <= 1'b0;
            trap_id_r <= 2'h0;
            core_reset <= 1'b1;
            vec_req <= 1'b0;
            vec_addr <= 16'h0000;
            pc_load <= 1'b0;
            pc_value <= 16'h0000;
            set_ibit <= 1'b0;
            vector_num <= VEC_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            req_pend_r <= req_pend_nxt;
            nmi_pend_r <= nmi_pend_nxt;
            trap_pend_r <= trap_pend_nxt;
            trap_id_r <= trap_id_nxt;
            core_reset <= core_reset_nxt;
            vec_req <= vec_req_nxt;
            vec_addr <= vec_addr_nxt;
            pc_load <= pc_load_nxt;
            pc_value <= pc_value_nxt;
            set_ibit <= set_ibit_nxt;
            vector_num <= vector_num_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_reset_wins: assert property ( // RULE1
        sys_rst |=> core_reset && !vec_req && state_r == st_hold)
        else $error("reset did not take precedence");
    a_wdt_same_entry: assert property ( // RULE2
        state_r == st_hold && !sys_rst |=> vec_req && vector_num == VEC_RESET
        && vec_addr == 16'h0000)
        else $error("reset entry does not use vector 0");
    a_trap_vector: assert property ( // RULE3
        state_r == st_run && instr_done && software_trap_instr && !nmi_pend_r
        && !trap_pend_r && !sys_rst
        |=> vector_num == VEC_TRAP0 + {3'h0, $past(trap_num)})
        else $error("trap vector not taken from opcode field");
    a_trap_ignores_mask: assert property ( // RULE4
        state_r == st_run && instr_done && software_trap_instr && ccr_ibit
        && !sys_rst |=> state_r == st_fetch)
        else $error("trap blocked by mask bit");
    a_mask_blocks: assert property ( // RULE5
        ccr_ibit |=> !set_ibit)
        else $error("maskable request accepted while masked");
    a_boundary_only: assert property ( // RULE6
        state_r == st_run && !instr_done |=> !vec_req)
        else $error("entry started mid-instruction");
    a_nmi_first: assert property ( // RULE7
        state_r == st_run && instr_done && nmi_pend_r && !sys_rst
        |=> vector_num == VEC_NMI)
        else $error("priority order broken");
    a_no_reserved: assert property ( // RULE9
        vec_req |-> !(vector_num inside {[VEC_RSVD_LO:VEC_RSVD_HI]}))
        else $error("reserved vector used");
    a_edge_rsvd: assert property ( // RULE13
        (edge_sel_r & EDGE_RSVD) == 8'h00)
        else $error("reserved edge select bits stored a write");
    a_edge_reset: assert property ( // RULE12
        sys_rst |=> edge_sel_r == EDGE_RESET)
        else $error("edge selects not cleared by reset");
    a_pc_load: assert property ( // RULE14
        state_r == st_fetch && vec_ack && !sys_rst
        |=> pc_load && pc_value == $past(vec_data) ##1 !pc_load)
        else $error("handler address not loaded");
    a_ibit_set: assert property ( // RULE15
        set_ibit |-> vector_num >= VEC_REQ0 && $past(req_pend_r) != 4'h0)
        else $error("mask bit set for wrong source");
endmodule // exc_vector_ctrl
`default_nettype wire

// ---- exception_vector_and_edge_select_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module exception_vector_and_edge_select_tb import exc_pkg::*;;
    localparam logic [33:0] NONE = {2'b10, 32'h0};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, core_reset, vec_req, pc_load, set_ibit;
    logic irq, vec_ack;
    logic reset_pin_n = 0, wdt_overflow = 0, nmi_pin = 1;
    logic instr_done = 0, software_trap_instr = 0, ccr_ibit = 1;
    logic break_req = 0, ib = 0, last_ib = 0;
    logic [3:0] ext_request_pins = 4'hf, ack_delay = 4'h0;
    logic [1:0] trap_num = 2'h0, tn;
    logic [15:0] vec_addr, pc_value, vec_data;
    logic [4:0] vector_num;
    logic [33:0] rdq[$], enq[$], e;
    int n_mismatch = 0, total_checks = 0, seed = 6, i;

    always #2.5 pclk = ~pclk;

    exc_vector_ctrl i_exc_vector_ctrl (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n,
        .wdt_overflow, .nmi_pin, .ext_request_pins, .instr_done,
        .software_trap_instr, .trap_num, .ccr_ibit, .break_req, .vec_ack,
        .vec_data, .core_reset, .vec_req, .vec_addr, .pc_load, .pc_value,
        .set_ibit, .vector_num, .irq);
    core_fetch_model i_core_fetch_model (.pclk, .presetn, .vec_req,
        .vec_addr, .ack_delay, .vec_ack, .vec_data);

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [33:0] ent(input logic [4:0] v);
        logic [7:0] a;
        begin
            a = {2'b00, v, 1'b0};
            return {13'h0, v, a, ~a};
        end
    endfunction

    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && rdq.size() > 0)
        begin
            e = rdq.pop_front();
            if (!e[33])
                cmp({1'b0, pslverr, prdata}, e);
        end
        if (set_ibit === 1'b1)
            ib <= 1'b1;
        if (pc_load === 1'b1)
        begin
            last_ib <= ib;
            ib <= 1'b0;
            if (enq.size() == 0)
                cmp({13'h0, vector_num, pc_value}, NONE);
            else
                cmp({13'h0, vector_num, pc_value}, enq.pop_front());
        end
    end

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        int n;
        begin
            if (!w)
                rdq.push_back(x);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 20);
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 20)
            begin
                n_mismatch++;
                stop_test();
            end
            @(posedge pclk);
        end
    endtask

    task automatic wait_load;
        int n;
        begin
            n = 0;
            while (pc_load !== 1'b1 && n < 60)
            begin
                @(posedge pclk);
                n++;
            end
            if (n >= 60)
            begin
                n_mismatch++;
                stop_test();
            end
            @(posedge pclk);
        end
    endtask

    // one instruction boundary; NONE means no entry may follow
    task automatic step(input logic [33:0] x);
        ack_delay <= 4'($random(seed)) & 4'h7;
        if (!x[33])
            enq.push_back(x);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        software_trap_instr <= 1'b0;
        if (x[33])
            repeat (20) @(posedge pclk);
        else
            wait_load();
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        cmp({33'h0, core_reset}, 34'h1);
        enq.push_back(ent(VEC_RESET));
        reset_pin_n <= 1'b1;
        wait_load();
        $display("test reset done");
        apb(1'b0, ADDR_EDGE_SEL, 32'h0, {26'h0, EDGE_RSVD});
        apb(1'b1, ADDR_EDGE_SEL, 32'hff, NONE);
        apb(1'b0, ADDR_EDGE_SEL, 32'h0, {26'h0, EDGE_RSVD | EDGE_RW});
        apb(1'b1, ADDR_EDGE_SEL, 32'h0, NONE);
        apb(1'b0, ADDR_EDGE_SEL, 32'h0, {26'h0, EDGE_RSVD});
        apb(1'b0, 12'h010, 32'h0, {2'b01, 32'h0});
        $display("test registers done");
        for (i = 0; i < 5; i++)
        begin
            tn = (i < 4) ? 2'(i) : 2'($random(seed));
            software_trap_instr <= 1'b1;
            trap_num <= tn;
            // the last trap ends its own instruction
            if (i < 4)
            begin
                @(posedge pclk);
                software_trap_instr <= 1'b0;
            end
            step(ent(VEC_TRAP0 + 5'(tn)));
        end
        $display("test traps done");
        nmi_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        step(ent(VEC_NMI));
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        step(NONE);
        apb(1'b1, ADDR_EDGE_SEL, 32'h8a, NONE);
        nmi_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        step(NONE);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        step(ent(VEC_NMI));
        $display("test nmi edge done");
        for (i = 0; i < 4; i++)
        begin
            ccr_ibit <= 1'b1;
            ext_request_pins[i] <= 1'b0;
            repeat (4) @(posedge pclk);
            step(NONE);
            ccr_ibit <= 1'b0;
            if (i % 2 == 1)
            begin
                step(NONE);
                ext_request_pins[i] <= 1'b1;
                repeat (4) @(posedge pclk);
            end
            step(ent(VEC_REQ0 + 5'(i)));
            cmp({33'h0, last_ib}, 34'h1);
        end
        $display("test request edges done");
        apb(1'b1, ADDR_EDGE_SEL, 32'h0, NONE);
        ext_request_pins <= 4'hf;
        ccr_ibit <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_pin <= 1'b0;
        ext_request_pins <= 4'h0;
        break_req <= 1'b1;
        software_trap_instr <= 1'b1;
        trap_num <= 2'h2;
        @(posedge pclk);
        software_trap_instr <= 1'b0;
        repeat (4) @(posedge pclk);
        step(ent(VEC_NMI));
        step(ent(VEC_TRAP0 + 5'h2));
        step(ent(VEC_BREAK));
        break_req <= 1'b0;
        ccr_ibit <= 1'b0;
        for (i = 0; i < 4; i++)
            step(ent(VEC_REQ0 + 5'(i)));
        $display("test priority done");
        apb(1'b1, ADDR_EDGE_SEL, 32'h8f, NONE);
        wdt_overflow <= 1'b1;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        @(posedge pclk);
        cmp({33'h0, core_reset}, 34'h1);
        enq.push_back(ent(VEC_RESET));
        wait_load();
        apb(1'b0, ADDR_EDGE_SEL, 32'h0, {26'h0, EDGE_RSVD});
        $display("test watchdog done");
        apb(1'b0, ADDR_STATUS, 32'h0, NONE);
        apb(1'b1, ADDR_MASK, 32'(1) << ST_NMI, NONE);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        step(ent(VEC_NMI));
        cmp({33'h0, irq}, 34'h1);
        apb(1'b0, ADDR_STATUS, 32'h0, {2'b00, 32'(1) << ST_NMI});
        repeat (2) @(posedge pclk);
        cmp({33'h0, irq}, 34'h0);
        apb(1'b1, ADDR_MASK, 32'h0, NONE);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        step(ent(VEC_NMI));
        cmp({33'h0, irq}, 34'h0);
        $display("test interrupt done");
        stop_test();
    end
endmodule // exception_vector_and_edge_select_tb
`default_nettype wire

// ---- pin_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic rise_sel,
    output logic level,
    output logic edge_seen
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ----------------------------------------
    // two-flop synchroniser, then history
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    // 0 falling, 1 rising
    assign edge_seen = rise_sel ? (sync_r & ~prev_r) : (~sync_r & prev_r); // RULE10 RULE11
endmodule // pin_edge_detect
`default_nettype wire
